// File: rtl/spc_pkg.sv
// shared constants for the serial port configuration register group
package spc_pkg;
   // register access port widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [11:0] OFS_CFG  = 12'h000;  // serial_port_config
   localparam logic [11:0] OFS_REV  = 12'h002;  // silicon_level
   localparam logic [11:0] OFS_ID   = 12'h003;  // variant_identifier
   localparam logic [11:0] OFS_SEL  = 12'h004;  // readback_bank_select
   localparam logic [11:0] OFS_BANK = 12'h005;  // first staged register

   // serial_port_config and readback_bank_select field positions
   localparam int CFG_SEP_BIT  = 7;  // separate output pin for reads
   localparam int CFG_LSB_BIT  = 6;  // lsb first, address increment
   localparam int CFG_SRST_BIT = 5;  // self-clearing soft reset
   localparam int SEL_ACT_BIT  = 0;  // readback from active bank

   // reset values
   localparam logic [1:0] CFG_HI_RST = 2'h0;
   localparam logic       SEL_RST    = 1'b0;
   localparam logic [7:0] BANK_RST   = 8'h00;

   // staged register count and read answer latency in clocks
   localparam int BANK_DEPTH = 2;
   localparam int RD_LAT     = 2;
endpackage : spc_pkg

// File: rtl/spc_bank.sv
`timescale 1ns/1ps
`default_nettype none
// staged (buffer) and active register pairs with registered read data
module spc_bank #(
   parameter int DEPTH = spc_pkg::BANK_DEPTH,
   parameter int W     = spc_pkg::DATA_W,
   parameter int IW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   // control
   input  wire logic          clr,
   input  wire logic          update,
   // write side
   input  wire logic          wr_en,
   input  wire logic [IW-1:0] wr_idx,
   input  wire logic [W-1:0]  wr_data,
   // read side
   input  wire logic          rd_en,
   input  wire logic [IW-1:0] rd_idx,
   input  wire logic          rd_active,
   output logic      [W-1:0]  rd_data
);
   import spc_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] buf_q;
      logic [DEPTH-1:0][W-1:0] act_q;
      logic [W-1:0]            rdat;
   } spc_bank_t;

   spc_bank_t bank_reg;
   spc_bank_t bank_next;

   // an index too narrow for the depth would alias registers
   if (DEPTH < 1 || W < 1 || W > 8 || IW < 1 || (1 << IW) < DEPTH)
   begin : g_chk
      $error("spc_bank: DEPTH >= 1, W in 1..8, IW must cover DEPTH");
   end

   // writes land in the buffer; active copies only on update
   always_comb begin
      bank_next = bank_reg;
      if (wr_en) begin
         bank_next.buf_q[wr_idx] = wr_data;
      end
      if (update) begin
         bank_next.act_q = bank_reg.buf_q;
      end
      if (rd_en) begin
         bank_next.rdat = rd_active ? bank_reg.act_q[rd_idx]
                                    : bank_reg.buf_q[rd_idx];
      end
      // soft reset wins over a same-cycle write or update
      if (clr) begin
         bank_next.buf_q = {DEPTH{W'(BANK_RST)}};
         bank_next.act_q = {DEPTH{W'(BANK_RST)}};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         bank_reg <= '{buf_q: {DEPTH{W'(BANK_RST)}},
                       act_q: {DEPTH{W'(BANK_RST)}},
                       rdat:  '0};
      end else begin
         bank_reg <= bank_next;
      end
   end

   assign rd_data = bank_reg.rdat;

   act_hold_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (!update && !clr) |=> $stable(bank_reg.act_q))
      else $error("active bank changed without update");

   act_copy_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (update && !clr) |=> bank_reg.act_q == $past(bank_reg.buf_q))
      else $error("update did not copy buffer to active");
endmodule  // spc_bank
`default_nettype wire

// File: rtl/spc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A mirrored config write means the same in either bit order.
// - Offset 0x002 reads a fixed silicon level and ignores writes.
// - Offset 0x003 reads a fixed code, distinct for each of six variants.
// - Bit 0 of 0x004 picks buffer (0) or active (1) registers for reads.
// - That readback select bit is 0 after reset.
// - Writing 1 to config bit 5 returns internal registers to defaults.
// - In I2C mode the soft reset bit clears on the clock after the write.
// - In SPI mode it clears likewise and leaves the config byte unchanged.
// - In SPI mode bit 6 selects lsb first with increment; not in I2C.
// - In SPI mode bit 7 moves reads to the separate output pin.
module spc_regs #(
   parameter logic [7:0]      SILICON_LEVEL = 8'h01,  // arbitrary value
   // arbitrary per-variant codes, all distinct
   parameter logic [5:0][7:0] VARIANT_CODES = {8'h5A, 8'h4B, 8'h3C,
                                               8'h2D, 8'h1E, 8'h0F},
   parameter int              VARIANT       = 0,
   parameter int              DEPTH         = spc_pkg::BANK_DEPTH
) (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   // serial mode strap level, 1 = I2C
   input  wire logic                      mode_i2c,
   // register write from the serial framer, one-cycle strobe
   input  wire logic                      wr_stb,
   input  wire logic [spc_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [spc_pkg::DATA_W-1:0] wr_data,
   // register read request and answer
   input  wire logic                      rd_stb,
   input  wire logic [spc_pkg::ADDR_W-1:0] rd_addr,
   output logic      [spc_pkg::DATA_W-1:0] rd_data,
   output logic                           rd_valid,
   // buffer-to-active update action, one-cycle pulse
   input  wire logic                      io_update,
   // configuration seen by the serial framer and the chip
   output logic                           lsb_first,
   output logic                           separate_output_enable,
   output logic                           soft_reset_out
);
   import spc_pkg::*;

   localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [1:0] cfg_hi;    // bits 7:6 of serial_port_config
      logic       srst;      // soft reset, self-clearing
      logic       bank_sel;  // readback from active bank
      logic       stage1;    // read accepted last cycle
      logic       from_bank;
      logic [7:0] loc_data;
      logic [7:0] rdat;
      logic       rvalid;
      logic       lsb_q;
      logic       sep_q;
   } spc_state_t;

   spc_state_t state_reg;
   spc_state_t state_next;

   logic [7:0] wr_byte;
   logic [7:0] bank_rdata;
   logic       lsb_eff;
   logic       cfg_wr;

   if (VARIANT < 0 || VARIANT > 5 || DEPTH < 1 ||
       DEPTH > (1 << ADDR_W) - int'(OFS_BANK)) begin : g_chk
      $error("spc_regs: VARIANT must be 0..5 and DEPTH must fit the map");
   end

   // bit-order reversal of a byte
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   // staged register window decode
   function automatic logic in_bank(input logic [ADDR_W-1:0] a);
      return (a >= OFS_BANK) && (a < OFS_BANK + ADDR_W'(DEPTH));
   endfunction

   function automatic logic [IW-1:0] bank_idx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - OFS_BANK;
      return d[IW-1:0];
   endfunction

   // configuration byte as read: low nibble mirrors high nibble
   function automatic logic [7:0] cfg_view(input logic [1:0] hi,
                                           input logic       sr);
      logic [7:0] h;
      h = {hi, sr, 1'b0, 4'h0};
      return h | rev8(h);
   endfunction

   // bit order applies only in SPI mode
   assign lsb_eff = !mode_i2c && state_reg.cfg_hi[0];
   // framer delivers bits in shift order; undo it here, so a mirrored
   // configuration byte decodes identically in either order
   assign wr_byte = lsb_eff ? rev8(wr_data) : wr_data;
   assign cfg_wr  = wr_stb && (wr_addr == OFS_CFG);

   // register writes, soft reset and the two-stage read path
   always_comb begin
      state_next      = state_reg;
      state_next.srst = 1'b0;  // clears one clock after the write
      if (wr_stb) begin
         case (wr_addr)
            OFS_CFG: begin
               state_next.cfg_hi = wr_byte[CFG_SEP_BIT:CFG_LSB_BIT];
               state_next.srst   = wr_byte[CFG_SRST_BIT];
            end
            OFS_SEL: state_next.bank_sel = wr_byte[SEL_ACT_BIT];
            default: ;  // level and identifier writes dropped
         endcase
      end
      // soft reset restores defaults but spares the config byte
      if (state_reg.srst) begin
         state_next.bank_sel = SEL_RST;
      end
      // stage 1: latch local value; bank reads its own register
      state_next.stage1    = rd_stb;
      state_next.from_bank = rd_stb && in_bank(rd_addr);
      if (rd_stb) begin
         case (rd_addr)
            OFS_CFG: state_next.loc_data = cfg_view(state_reg.cfg_hi,
                                                    state_reg.srst);
            OFS_REV: state_next.loc_data = SILICON_LEVEL;
            OFS_ID:  state_next.loc_data = VARIANT_CODES[VARIANT];
            OFS_SEL: state_next.loc_data = {7'h00, state_reg.bank_sel};
            default: state_next.loc_data = 8'h00;  // unmapped reads zero
         endcase
      end
      // stage 2: answer in the current bit order
      state_next.rvalid = state_reg.stage1;
      if (state_reg.stage1) begin
         state_next.rdat = lsb_eff ?
            rev8(state_reg.from_bank ? bank_rdata : state_reg.loc_data) :
            (state_reg.from_bank ? bank_rdata : state_reg.loc_data);
      end
      // pin arrangement and order only matter in SPI mode
      state_next.lsb_q = !mode_i2c && state_next.cfg_hi[0];
      state_next.sep_q = !mode_i2c && state_next.cfg_hi[1];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_reg <= '{cfg_hi: CFG_HI_RST, bank_sel: SEL_RST,
                        default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // staged registers; active copy follows the update action
   spc_bank #(
      .DEPTH (DEPTH),
      .W     (DATA_W),
      .IW    (IW)
   ) u_bank (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .clr       (state_reg.srst),
      .update    (io_update),
      .wr_en     (wr_stb && in_bank(wr_addr)),
      .wr_idx    (bank_idx(wr_addr)),
      .wr_data   (wr_byte),
      .rd_en     (rd_stb && in_bank(rd_addr)),
      .rd_idx    (bank_idx(rd_addr)),
      .rd_active (state_reg.bank_sel),
      .rd_data   (bank_rdata)
   );

   // outputs straight from flip-flops
   assign rd_data                = state_reg.rdat;
   assign rd_valid               = state_reg.rvalid;
   assign lsb_first              = state_reg.lsb_q;
   assign separate_output_enable = state_reg.sep_q;
   assign soft_reset_out         = state_reg.srst;

   // soft reset request and its one-clock pulse
   sequence srst_arm_s;
      cfg_wr && wr_byte[CFG_SRST_BIT] ##1 !cfg_wr;
   endsequence
   sequence srst_pulse_s;
      soft_reset_out ##1 !soft_reset_out;
   endsequence

   srst_pulse_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      srst_arm_s |-> srst_pulse_s)
      else $error("soft reset did not pulse for exactly one clock");

   cfg_keep_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (soft_reset_out && !cfg_wr) |=> $stable(state_reg.cfg_hi))
      else $error("soft reset disturbed the configuration byte");

   sel_clear_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      soft_reset_out |=> !state_reg.bank_sel)
      else $error("soft reset left readback select set");

   sel_default_a: assert property (@(posedge core_clk)
      !rst_b |=> !state_reg.bank_sel && !lsb_first)
      else $error("readback select not cleared by reset");

   // a function result cannot be part-selected, so the mirror is spelt out
   order_same_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (cfg_wr && wr_data[3:0] ==
       {wr_data[4], wr_data[5], wr_data[6], wr_data[7]})
      |=> state_reg.cfg_hi == $past(wr_data[7:6]))
      else $error("mirrored config byte decoded by bit order");

   rev_read_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (rd_stb && rd_addr == OFS_REV) |-> ##2 rd_valid &&
      rd_data == ($past(lsb_eff) ? rev8(SILICON_LEVEL) : SILICON_LEVEL))
      else $error("silicon level read wrong");

   id_read_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (rd_stb && rd_addr == OFS_ID && !lsb_eff && !cfg_wr) |-> ##2
      rd_valid && rd_data == VARIANT_CODES[VARIANT])
      else $error("variant identifier read wrong");

   bank_pick_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (rd_stb && in_bank(rd_addr)) |=> state_reg.from_bank &&
      bank_rdata == ($past(state_reg.bank_sel) ?
         $past(u_bank.bank_reg.act_q[bank_idx(rd_addr)]) :
         $past(u_bank.bank_reg.buf_q[bank_idx(rd_addr)])))
      else $error("readback taken from the wrong bank");

   spi_only_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      mode_i2c |=> !lsb_first && !separate_output_enable)
      else $error("SPI-only bits acted in I2C mode");

   sep_follow_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (!mode_i2c && cfg_wr) |=> separate_output_enable == $past(wr_byte[7]))
      else $error("separate output pin select not applied");
endmodule  // spc_regs
`default_nettype wire

// File: testbench/spc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host-side model: frames single byte writes and reads onto the strobes
module spc_host (
   // clock
   input  wire logic                       core_clk,
   // write side
   output logic                            wr_stb,
   output logic [spc_pkg::ADDR_W-1:0]      wr_addr,
   output logic [spc_pkg::DATA_W-1:0]      wr_data,
   // read side
   output logic                            rd_stb,
   output logic [spc_pkg::ADDR_W-1:0]      rd_addr,
   input  wire logic [spc_pkg::DATA_W-1:0] rd_data,
   input  wire logic                       rd_valid,
   // update action and shift order
   output logic                            io_update,
   input  wire logic                       lsb_first
);
   import spc_pkg::*;

   // idle levels from time zero
   initial begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      io_update = 1'b0;
      wr_addr = 12'h000;
      rd_addr = 12'h000;
      wr_data = 8'h00;
   end

   // lsb first framing shows up as a reversed byte
   function automatic logic [7:0] rev(input logic [7:0] d);
      for (int i = 0; i < 8; i++) rev[i] = d[7-i];
   endfunction

   // configuration byte with its mirrored low nibble
   function automatic logic [7:0] cfg(input logic [3:0] hi);
      cfg = {hi, hi[0], hi[1], hi[2], hi[3]};
   endfunction

   // one byte write, taken at the next rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      wr_stb = 1'b1;
      wr_addr = a;
      wr_data = lsb_first ? rev(d) : d;
      @(posedge core_clk);
      #1;
      wr_stb = 1'b0;
      wr_data = ~wr_data;  // stale data must not look valid
   endtask

   // one byte read, answer awaited for a bounded number of clocks
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      int n;
      @(posedge core_clk);
      #1;
      rd_stb = 1'b1;
      rd_addr = a;
      @(posedge core_clk);
      #1;
      rd_stb = 1'b0;
      n = 0;
      while (rd_valid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      // a missing answer comes back unknown, so the caller's compare fails
      if (rd_valid !== 1'b1) begin
         d = 8'hXX;
      end else begin
         d = lsb_first ? rev(rd_data) : rd_data;
      end
   endtask

   // one-cycle update action
   task automatic upd();
      @(posedge core_clk);
      #1;
      io_update = 1'b1;
      @(posedge core_clk);
      #1;
      io_update = 1'b0;
   endtask
endmodule  // spc_host
`default_nettype wire

// File: testbench/spc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module spc_regs_bench;
   import spc_pkg::*;
   localparam logic [7:0]      LEVEL = 8'h37;  // arbitrary value
   // arbitrary distinct codes
   localparam logic [5:0][7:0] CODES = {8'h91, 8'h82, 8'h73,
                                        8'h64, 8'h55, 8'h46};
   localparam int              VAR   = 4;

   logic        core_clk;
   logic        rst_b;
   logic        mode_i2c;
   logic        wr_stb;
   logic        rd_stb;
   logic        io_update;
   logic [11:0] wr_addr;
   logic [11:0] rd_addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        lsb_first;
   logic        sep_en;
   logic        srst;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cyc = 0;

   spc_regs #(.SILICON_LEVEL(LEVEL), .VARIANT_CODES(CODES),
              .VARIANT(VAR), .DEPTH(2)) u_spc_regs (
      .core_clk(core_clk), .rst_b(rst_b), .mode_i2c(mode_i2c),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .io_update(io_update),
      .lsb_first(lsb_first), .separate_output_enable(sep_en),
      .soft_reset_out(srst));

   spc_host u_spc_host (
      .core_clk(core_clk), .wr_stb(wr_stb), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_stb(rd_stb), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid), .io_update(io_update),
      .lsb_first(lsb_first));

   // 50 ns clock
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   // the run needs about a hundred clocks; a hang is cut off well after
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
      end
   endtask

   // levels straight out of reset
   task automatic t_reset();
      logic [7:0] d;
      u_spc_host.rd(OFS_SEL, d);
      chk(d, 8'h00, "select at reset");
      chk({6'h00, sep_en, lsb_first}, 8'h00, "layout at reset");
   endtask

   // identification bytes ignore writes
   task automatic t_ident();
      logic [7:0] d;
      u_spc_host.wr(OFS_REV, ~LEVEL);
      u_spc_host.wr(OFS_ID, ~CODES[VAR]);
      u_spc_host.rd(OFS_REV, d);
      chk(d, LEVEL, "level");
      u_spc_host.rd(OFS_ID, d);
      chk(d, CODES[VAR], "variant");
   endtask

   // buffer against active readback around an update
   task automatic t_bank();
      logic [7:0] d;
      u_spc_host.wr(OFS_BANK, 8'h3C);
      u_spc_host.wr(OFS_BANK + 12'h001, 8'hC5);
      u_spc_host.rd(OFS_BANK, d);
      chk(d, 8'h3C, "buffer");
      u_spc_host.wr(OFS_SEL, 8'h01);
      u_spc_host.rd(OFS_SEL, d);
      chk(d, 8'h01, "select");
      u_spc_host.rd(OFS_BANK + 12'h001, d);
      chk(d, 8'h00, "active early");
      u_spc_host.upd();
      u_spc_host.rd(OFS_BANK + 12'h001, d);
      chk(d, 8'hC5, "active");
   endtask

   // self-clearing soft reset in either serial mode
   task automatic t_soft(input logic i2c);
      logic [7:0] d;
      mode_i2c = i2c;
      u_spc_host.wr(OFS_BANK, 8'h5A);
      u_spc_host.wr(OFS_SEL, 8'h01);
      u_spc_host.upd();
      u_spc_host.wr(OFS_CFG, u_spc_host.cfg(4'hA));
      chk({7'h00, srst}, 8'h01, "reset pulse");
      @(posedge core_clk);
      #1;
      chk({7'h00, srst}, 8'h00, "self clear");
      chk({7'h00, sep_en}, {7'h00, ~i2c}, "pin kept");
      u_spc_host.rd(OFS_SEL, d);
      chk(d, 8'h00, "select cleared");
      u_spc_host.rd(OFS_BANK, d);
      chk(d, 8'h00, "buffer cleared");
      if (!i2c) begin
         u_spc_host.rd(OFS_CFG, d);
         chk(d, 8'h81, "config kept");
      end
      u_spc_host.wr(OFS_CFG, 8'h00);
   endtask

   // shift order and pin layout, then both ignored in I2C
   task automatic t_order();
      logic [7:0] d;
      mode_i2c = 1'b0;
      u_spc_host.wr(OFS_CFG, u_spc_host.cfg(4'h4));
      chk({6'h00, sep_en, lsb_first}, 8'h01, "lsb first");
      u_spc_host.wr(OFS_CFG, u_spc_host.cfg(4'hC));
      chk({6'h00, sep_en, lsb_first}, 8'h03, "lsb config");
      u_spc_host.wr(OFS_BANK, 8'h01);
      u_spc_host.rd(OFS_BANK, d);
      chk(d, 8'h01, "lsb byte");
      mode_i2c = 1'b1;
      @(posedge core_clk);
      #1;
      chk({6'h00, sep_en, lsb_first}, 8'h00, "i2c off");
      mode_i2c = 1'b0;
      u_spc_host.wr(OFS_CFG, 8'h00);
      chk({7'h00, lsb_first}, 8'h00, "msb first");
   endtask

   // reset, then the scenarios in turn
   initial begin
      mode_i2c = 1'b0;
      rst_b = 1'b0;
      repeat (16) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_ident();
      t_bank();
      t_soft(1'b0);
      t_soft(1'b1);
      t_order();
      end_sim();
   end
endmodule  // spc_regs_bench
`default_nettype wire
